//--- src/sdc_axil_slave.sv
// AXI4-Lite slave front end: accepts one write and one read at a time.
`timescale 1ns/100ps
module sdc_axil_slave
	import sdc_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Write channels.
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read channels.
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register file side.
	output logic wr_en,
	output logic [31:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_hit,
	input wire logic [31:0] rd_data,
	input wire logic rd_hit
);

	logic aw_full;
	logic w_full;
	logic next_aw_full;
	logic next_w_full;
	logic next_rvalid;
	wire aw_take = awvalid & awready;
	wire w_take = wvalid & wready;
	wire ar_take = arvalid & arready;

	// The write goes ahead once both halves are held and the last answer is gone.
	assign wr_en = aw_full & w_full & ~bvalid;
	assign next_aw_full = wr_en ? 1'b0 : (aw_full | aw_take);
	assign next_w_full = wr_en ? 1'b0 : (w_full | w_take);
	assign next_rvalid = ar_take | (rvalid & ~rready);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= '0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			awready <= ~next_aw_full;
			wready <= ~next_w_full;
			if (aw_take) begin
				wr_addr <= awaddr;
			end
			if (w_take) begin
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_en) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			rvalid <= next_rvalid;
			arready <= ~next_rvalid;
			if (ar_take) begin
				rdata <= rd_hit ? rd_data : '0;
				rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	read_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
		ar_take |=> (rvalid && !arready))
		else $error("read not answered on the next cycle");

endmodule : sdc_axil_slave

//--- src/sdc_dma_cfg_irq.sv
// Top of the DMA channel configuration and interrupt register block.
//
// Functional notes
// - Registers sit at base 0x3FF58000: config, raw, status, enable, clear at 0..0x10.
// - Send owner writeback bit lets the engine update send descriptor owner bits.
// - Send loop test wraps the send list and leaves owner bits alone.
// - Receive loop test wraps the receive list and leaves owner bits alone.
// - Send state machine is held in reset while its reset bit is set.
// - Receive state machine is held in reset while its reset bit is set.
// - Raw flag for a descriptor error while sending.
// - Raw flag for a descriptor error while receiving.
// - Raw flag when a whole send operation has finished.
// - Raw flag each time one send buffer is fully sent.
// - Raw flag when a receive operation completes successfully.
// - Raw flag each time one receive buffer is filled.
// - Raw flag on receive buffer overflow.
// - Raw flag on send buffer underflow.
// - Separate raw flags for receive start and send start.
// - Eight raw flags set by the matching host-to-slave vector bits.
// - Each raw flag has a matching read-only status bit elsewhere.
// - One read/write enable bit per DMA event source.
// - Eight read/write enable bits for the host vector bits.
// - Host vector bits clear themselves right after signalling.
`timescale 1ns/100ps
module sdc_dma_cfg_irq
	import sdc_pkg::*;
(
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic RST_N,
	// AXI4-Lite write channels.
	input wire logic [31:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read channels.
	input wire logic [31:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	// DMA engine event pulses.
	input wire logic SEND_DESCRIPTOR_ERROR,
	input wire logic RECEIVE_DESCRIPTOR_ERROR,
	input wire logic SEND_COMPLETE,
	input wire logic SEND_BUFFER_DONE,
	input wire logic RECEIVE_COMPLETE,
	input wire logic RECEIVE_BUFFER_DONE,
	input wire logic RECEIVE_OVERFLOW,
	input wire logic SEND_UNDERFLOW,
	input wire logic RECEIVE_START,
	input wire logic SEND_START,
	// Host-side vector write.
	input wire logic HOST_VECTOR_WR,
	input wire logic [7:0] HOST_VECTOR_DATA,
	// DMA engine controls.
	output logic SEND_FSM_RESET,
	output logic RECEIVE_FSM_RESET,
	output logic SEND_OWNER_WRITEBACK,
	output logic RECEIVE_OWNER_WRITEBACK,
	output logic SEND_LOOP_WRAP,
	output logic RECEIVE_LOOP_WRAP,
	output logic TOKEN_AUTO_CLEAR,
	// Host vector and processor interrupt.
	output logic [7:0] HOST_VECTOR_PENDING,
	output logic IRQ_OUT
);

	////////////////////////////////////////////////////////////////////////////////
	// Byte-lane merge used by the config and enable registers.
	function automatic logic [31:0] merge_lanes(
		input logic [31:0] old_value,
		input logic [31:0] new_value,
		input logic [3:0] strb
	);
		logic [31:0] result;
		result = old_value;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				result[i*8 +: 8] = new_value[i*8 +: 8];
			end
		end
		return result;
	endfunction : merge_lanes

	// Word decode against the block base.
	function automatic logic is_reg(
		input logic [31:0] addr,
		input logic [7:0] offset
	);
		return ((addr & SDC_SPAN_MASK) == SDC_BASE) && (addr[7:0] == offset);
	endfunction : is_reg

	////////////////////////////////////////////////////////////////////////////////
	// Register state.
	logic [CFG_W-1:0] config_reg;
	logic [FLAG_W-1:0] enable_reg;
	logic [FLAG_W-1:0] raw_flags;
	logic [HOSTV_W-1:0] host_vector;
	logic [HOSTV_W-1:0] next_host_vector;
	logic [CFG_W-1:0] next_config;
	logic [FLAG_W-1:0] next_enable;

	// Bus request side.
	logic wr_en;
	logic [31:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_data;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.
	wire wr_cfg = wr_en & is_reg(wr_addr, OFS_CONFIG);
	wire wr_ena = wr_en & is_reg(wr_addr, OFS_ENABLE);
	wire wr_clr = wr_en & is_reg(wr_addr, OFS_CLEAR);
	wire wr_hit = is_reg(wr_addr, OFS_CONFIG) | is_reg(wr_addr, OFS_ENABLE)
		| is_reg(wr_addr, OFS_CLEAR) | is_reg(wr_addr, OFS_RAW)
		| is_reg(wr_addr, OFS_STATUS);
	wire rd_cfg = is_reg(ARADDR, OFS_CONFIG);
	wire rd_raw = is_reg(ARADDR, OFS_RAW);
	wire rd_sts = is_reg(ARADDR, OFS_STATUS);
	wire rd_ena = is_reg(ARADDR, OFS_ENABLE);
	wire rd_clr = is_reg(ARADDR, OFS_CLEAR);
	wire rd_hit = rd_cfg | rd_raw | rd_sts | rd_ena | rd_clr;

	////////////////////////////////////////////////////////////////////////////////
	// Event and status wiring.
	wire [EVENT_W-1:0] dma_events = {
		SEND_START,
		RECEIVE_START,
		SEND_UNDERFLOW,
		RECEIVE_OVERFLOW,
		RECEIVE_BUFFER_DONE,
		RECEIVE_COMPLETE,
		SEND_BUFFER_DONE,
		SEND_COMPLETE,
		RECEIVE_DESCRIPTOR_ERROR,
		SEND_DESCRIPTOR_ERROR
	};
	wire [FLAG_W-1:0] flag_set = {dma_events, host_vector};
	wire [FLAG_W-1:0] flag_clear = wr_clr ? (wr_data[FLAG_W-1:0]
		& {{(FLAG_W-16){wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}}) : '0;
	wire [FLAG_W-1:0] status_flags = raw_flags & enable_reg;

	// Read multiplexer; the clear register reads as zero.
	assign rd_data = rd_cfg ? {{(32-CFG_W){1'b0}}, config_reg}
		: rd_raw ? {{(32-FLAG_W){1'b0}}, raw_flags}
		: rd_sts ? {{(32-FLAG_W){1'b0}}, status_flags}
		: rd_ena ? {{(32-FLAG_W){1'b0}}, enable_reg}
		: 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Next register values.
	wire [31:0] cfg_merged = merge_lanes({{(32-CFG_W){1'b0}}, config_reg}, wr_data, wr_strb);
	wire [31:0] ena_merged = merge_lanes({{(32-FLAG_W){1'b0}}, enable_reg}, wr_data, wr_strb);
	assign next_config = wr_cfg ? cfg_merged[CFG_W-1:0] : config_reg;
	assign next_enable = wr_ena ? ena_merged[FLAG_W-1:0] : enable_reg;

	// A host write raises the vector for one cycle only, then it drops by itself.
	assign next_host_vector = HOST_VECTOR_WR ? HOST_VECTOR_DATA : HOSTV_NONE;

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave.
	sdc_axil_slave u_bus (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.awaddr(AWADDR),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.wvalid(WVALID),
		.wready(WREADY),
		.bresp(BRESP),
		.bvalid(BVALID),
		.bready(BREADY),
		.araddr(ARADDR),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.rvalid(RVALID),
		.rready(RREADY),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_hit(wr_hit),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// Raw interrupt flags.
	sdc_sticky_flags #(
		.WIDTH(FLAG_W)
	) u_raw (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.set(flag_set),
		.clear(flag_clear),
		.flags(raw_flags)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register and output flops.
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			config_reg <= CFG_RESET;
			enable_reg <= ENA_RESET;
			host_vector <= HOSTV_NONE;
		end else begin
			config_reg <= next_config;
			enable_reg <= next_enable;
			host_vector <= next_host_vector;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SEND_FSM_RESET <= 1'b0;
			RECEIVE_FSM_RESET <= 1'b0;
			SEND_OWNER_WRITEBACK <= 1'b0;
			RECEIVE_OWNER_WRITEBACK <= 1'b0;
			SEND_LOOP_WRAP <= 1'b0;
			RECEIVE_LOOP_WRAP <= 1'b0;
			TOKEN_AUTO_CLEAR <= 1'b0;
			HOST_VECTOR_PENDING <= HOSTV_NONE;
			IRQ_OUT <= 1'b0;
		end else begin
			SEND_FSM_RESET <= config_reg[CFG_SEND_RST];
			RECEIVE_FSM_RESET <= config_reg[CFG_RECV_RST];
			SEND_OWNER_WRITEBACK <= config_reg[CFG_SEND_WRBACK]
				& ~config_reg[CFG_SEND_LOOP];
			RECEIVE_OWNER_WRITEBACK <= ~config_reg[CFG_RECV_LOOP];
			SEND_LOOP_WRAP <= config_reg[CFG_SEND_LOOP];
			RECEIVE_LOOP_WRAP <= config_reg[CFG_RECV_LOOP];
			TOKEN_AUTO_CLEAR <= config_reg[CFG_TOKEN_CLR];
			HOST_VECTOR_PENDING <= host_vector;
			IRQ_OUT <= |status_flags;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	send_reset_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(wr_cfg && wr_strb[0]) |-> ##2 (SEND_FSM_RESET == $past(wr_data[CFG_SEND_RST], 2)))
		else $error("send reset does not follow the config write");

	recv_reset_hold_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(wr_cfg && wr_strb[0]) |-> ##2 (RECEIVE_FSM_RESET == $past(wr_data[CFG_RECV_RST], 2)))
		else $error("receive reset does not follow the config write");

	owner_loop_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		$past(config_reg[CFG_SEND_LOOP]) |-> !SEND_OWNER_WRITEBACK)
		else $error("owner writeback active during send loop test");

	recv_owner_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		RECEIVE_LOOP_WRAP |-> !RECEIVE_OWNER_WRITEBACK)
		else $error("owner writeback active during receive loop test");

	event_capture_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(dma_events != '0) |=> ((raw_flags[FLAG_W-1:EVENT_LSB] & $past(dma_events))
			== $past(dma_events)))
		else $error("DMA event not captured in raw flags");

	host_bit_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(HOST_VECTOR_WR && HOST_VECTOR_DATA[0]) |-> ##2 raw_flags[0])
		else $error("host vector bit 0 not captured");

	vector_self_clear_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(host_vector != HOSTV_NONE && !HOST_VECTOR_WR) |=> (host_vector == HOSTV_NONE))
		else $error("host vector did not clear itself");

	irq_mask_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(enable_reg == ENA_RESET) |=> !IRQ_OUT)
		else $error("interrupt raised with all enables off");

	clear_flag_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(flag_clear[0] && !flag_set[0]) |=> !raw_flags[0])
		else $error("raw flag survived its clear");

	status_pair_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(raw_flags[EVENT_LSB] && enable_reg[EVENT_LSB]) |=> IRQ_OUT)
		else $error("enabled raw flag did not raise the interrupt");

	send_loop_copy_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(wr_cfg && wr_strb[0]) |-> ##2 (SEND_LOOP_WRAP == $past(wr_data[CFG_SEND_LOOP], 2)))
		else $error("send loop output does not follow the config write");

	recv_loop_copy_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(wr_cfg && wr_strb[0]) |-> ##2 (RECEIVE_LOOP_WRAP == $past(wr_data[CFG_RECV_LOOP], 2)))
		else $error("receive loop output does not follow the config write");

	writeback_copy_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(wr_cfg && wr_strb[0]) |-> ##2 (SEND_OWNER_WRITEBACK
			== ($past(wr_data[CFG_SEND_WRBACK], 2) && !$past(wr_data[CFG_SEND_LOOP], 2))))
		else $error("send owner writeback does not follow the config write");

	recv_owner_copy_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(wr_cfg && wr_strb[0]) |-> ##2 (RECEIVE_OWNER_WRITEBACK
			== !$past(wr_data[CFG_RECV_LOOP], 2)))
		else $error("receive owner writeback does not follow the config write");

	config_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(wr_cfg && wr_strb[0]) |=> (config_reg == $past(wr_data[CFG_W-1:0])))
		else $error("config register missed a write");

	enable_write_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(wr_ena && (&wr_strb)) |=> (enable_reg == $past(wr_data[FLAG_W-1:0])))
		else $error("enable register missed a write");

	irq_follow_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(status_flags != '0) |=> IRQ_OUT)
		else $error("interrupt missing for an enabled flag");

	irq_quiet_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(status_flags == '0) |=> !IRQ_OUT)
		else $error("interrupt raised with no status bit");

	pending_quiet_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(host_vector == HOSTV_NONE) |=> (HOST_VECTOR_PENDING == HOSTV_NONE))
		else $error("host vector pending without a host write");

	host_all_bits_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(host_vector != HOSTV_NONE) |=> ((raw_flags[HOSTV_W-1:0] & $past(host_vector))
			== $past(host_vector)))
		else $error("host vector bit not captured");

	raw_rise_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		1'b1 |=> ((raw_flags & ~$past(raw_flags) & ~$past(flag_set)) == '0))
		else $error("raw flag rose without its event");

	clear_all_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(flag_clear != '0) |=> ((raw_flags & $past(flag_clear) & ~$past(flag_set)) == '0))
		else $error("a cleared raw flag stayed set");

	raw_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(ARVALID && ARREADY && rd_raw) |=> (RDATA == {{(32-FLAG_W){1'b0}}, $past(raw_flags)}))
		else $error("raw flags read back wrong");

	status_read_a: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(ARVALID && ARREADY && rd_sts)
			|=> (RDATA == {{(32-FLAG_W){1'b0}}, $past(status_flags)}))
		else $error("status flags read back wrong");

endmodule : sdc_dma_cfg_irq

//--- src/sdc_pkg.sv
// Register map, field layout and bus constants for the DMA configuration and interrupt block.
package sdc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map.
	localparam logic [31:0] SDC_BASE = 32'h3FF5_8000;
	localparam logic [31:0] SDC_SPAN_MASK = 32'hFFFF_FF00;
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_RAW = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_ENABLE = 8'h0C;
	localparam logic [7:0] OFS_CLEAR = 8'h10;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration register fields.
	localparam int CFG_W = 6;
	localparam int CFG_RECV_RST = 0;
	localparam int CFG_SEND_RST = 1;
	localparam int CFG_RECV_LOOP = 2;
	localparam int CFG_SEND_LOOP = 3;
	localparam int CFG_SEND_WRBACK = 4;
	localparam int CFG_TOKEN_CLR = 5;
	localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt flag layout: host vector bits low, DMA events above them.
	localparam int HOSTV_W = 8;
	localparam int EVENT_W = 10;
	localparam int EVENT_LSB = 8;
	localparam int FLAG_W = 18;
	localparam logic [FLAG_W-1:0] ENA_RESET = 18'h00000;
	localparam logic [HOSTV_W-1:0] HOSTV_NONE = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Bus answers.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sdc_pkg

//--- src/sdc_sticky_flags.sv
// Sticky event flags: set by hardware pulses, cleared by write-one-to-clear.
`timescale 1ns/100ps
module sdc_sticky_flags
	import sdc_pkg::*;
#(
	parameter int WIDTH = FLAG_W
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Set and clear requests.
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clear,
	// Flag state.
	output logic [WIDTH-1:0] flags
);

	logic [WIDTH-1:0] next_flags;

	// A set in the same cycle as its clear is kept.
	assign next_flags = (flags & ~clear) | set;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= '0;
		end else begin
			flags <= next_flags;
		end
	end

	set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
		(set != '0) |=> ((flags & $past(set)) == $past(set)))
		else $error("a set flag was lost");

	flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> ((flags & ~$past(clear) & $past(flags)) == ($past(flags) & ~$past(clear))))
		else $error("a flag dropped without a clear");

endmodule : sdc_sticky_flags

//--- tb/tb_sdc_dma_cfg_irq.sv
// Self-checking bench for the DMA configuration and interrupt register block.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("BAD %0t %s got %h exp %h", $time, msg, got, exp); \
	end \
end
module tb import sdc_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
	logic [3:0] wstrb = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [9:0] ev = '0;
	logic hv_wr = 1'b0;
	logic [7:0] hv_data = '0;
	logic awready, wready, bvalid, arready, rvalid, recv_owb, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd;
	logic [1:0] rsp;
	wire [5:0] ctl;
	logic [7:0] pend;
	int miscompares = 0;
	int cmp_count = 0;

	always #5 clk = ~clk;

	sdc_dma_cfg_irq u_dut (
		.REF_CLK(clk), .RST_N(rst_n),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
		.RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.SEND_DESCRIPTOR_ERROR(ev[0]), .RECEIVE_DESCRIPTOR_ERROR(ev[1]),
		.SEND_COMPLETE(ev[2]), .SEND_BUFFER_DONE(ev[3]),
		.RECEIVE_COMPLETE(ev[4]), .RECEIVE_BUFFER_DONE(ev[5]),
		.RECEIVE_OVERFLOW(ev[6]), .SEND_UNDERFLOW(ev[7]),
		.RECEIVE_START(ev[8]), .SEND_START(ev[9]),
		.HOST_VECTOR_WR(hv_wr), .HOST_VECTOR_DATA(hv_data),
		.SEND_FSM_RESET(ctl[1]), .RECEIVE_FSM_RESET(ctl[0]),
		.SEND_OWNER_WRITEBACK(ctl[4]), .RECEIVE_OWNER_WRITEBACK(recv_owb),
		.SEND_LOOP_WRAP(ctl[3]), .RECEIVE_LOOP_WRAP(ctl[2]),
		.TOKEN_AUTO_CLEAR(ctl[5]),
		.HOST_VECTOR_PENDING(pend), .IRQ_OUT(irq)
	);

	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic axw(input logic [7:0] ofs, input logic [31:0] d, input logic [3:0] be = 4'hF);
		bit aw, w;
		aw = 0;
		w = 0;
		@(posedge clk);
		awaddr <= SDC_BASE + 32'(ofs);
		wdata <= d;
		wstrb <= be;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] ofs);
		@(posedge clk);
		araddr <= SDC_BASE + 32'(ofs);
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : axr

	task automatic rchk(input logic [7:0] ofs, input logic [31:0] exp, input string msg);
		axr(ofs);
		`CHK(rd, exp, msg)
		`CHK(rsp, RESP_OKAY, "read resp")
	endtask : rchk

	task automatic hostw(input logic [7:0] v);
		@(posedge clk);
		hv_wr <= 1'b1;
		hv_data <= v;
		@(posedge clk);
		hv_wr <= 1'b0;
	endtask : hostw

	////////////////////////////////////////
	task automatic t_reset();
		`CHK({ctl, recv_owb, pend, irq}, {6'h00, 1'b1, 8'h00, 1'b0}, "reset outs")
		rchk(OFS_CONFIG, 32'(CFG_RESET), "config rst");
		rchk(OFS_RAW, 32'h0, "raw rst");
		rchk(OFS_STATUS, 32'h0, "status rst");
		rchk(OFS_ENABLE, 32'(ENA_RESET), "enable rst");
		rchk(OFS_CLEAR, 32'h0, "clear reads");
	endtask : t_reset

	task automatic t_map();
		axr(8'h14);
		`CHK({rsp, rd}, {RESP_SLVERR, 32'h0}, "unmapped read")
		axw(8'h14, 32'hFFFF_FFFF);
		`CHK(rsp, RESP_SLVERR, "unmapped write")
		axw(OFS_RAW, 32'hFFFF_FFFF);
		`CHK(rsp, RESP_OKAY, "raw write resp")
		rchk(OFS_RAW, 32'h0, "raw is RO");
		axw(OFS_STATUS, 32'hFFFF_FFFF);
		rchk(OFS_STATUS, 32'h0, "status is RO");
	endtask : t_map

	task automatic t_config();
		logic [5:0] tab [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h1F, 6'h00};
		logic [5:0] v;
		foreach (tab[i]) begin
			v = tab[i];
			axw(OFS_CONFIG, 32'(v));
			`CHK(rsp, RESP_OKAY, "cfg write resp")
			tick(1);
			`CHK(ctl, {v[5], v[4] & ~v[3], v[3:0]}, "cfg outs")
			`CHK(recv_owb, ~v[2], "recv writeback")
			rchk(OFS_CONFIG, 32'(v), "cfg readback");
		end
	endtask : t_config

	task automatic t_events();
		logic [31:0] e;
		e = 32'h0;
		for (int i = 0; i < EVENT_W; i++) begin
			@(posedge clk);
			ev <= 10'(1) << i;
			@(posedge clk);
			ev <= '0;
			e |= 32'(1) << (EVENT_LSB + i);
			rchk(OFS_RAW, e, "event raw");
			rchk(OFS_STATUS, 32'h0, "masked");
			`CHK(irq, 1'b0, "irq masked")
		end
		axw(OFS_ENABLE, e);
		rchk(OFS_ENABLE, e, "enable rw");
		rchk(OFS_STATUS, e, "status all");
		`CHK(irq, 1'b1, "irq on")
		axw(OFS_CLEAR, e & ~32'h100);
		rchk(OFS_RAW, 32'h100, "partial clear");
		`CHK(irq, 1'b1, "irq held")
		axw(OFS_ENABLE, e & ~32'h100);
		rchk(OFS_STATUS, 32'h0, "status off");
		rchk(OFS_RAW, 32'h100, "raw sticky");
		`CHK(irq, 1'b0, "irq off")
		axw(OFS_CLEAR, 32'h100);
		rchk(OFS_RAW, 32'h0, "raw cleared");
		axw(OFS_ENABLE, 32'h0, 4'h3);
		rchk(OFS_ENABLE, 32'h0003_0000, "enable lanes");
	endtask : t_events

	task automatic t_host();
		int n;
		n = 0;
		axw(OFS_ENABLE, 32'hFF);
		hostw(8'hA5);
		repeat (4) begin
			@(posedge clk);
			#1;
			if (pend === 8'hA5) n++;
		end
		`CHK(n, 1, "pending one cycle")
		`CHK(pend, HOSTV_NONE, "pending gone")
		rchk(OFS_RAW, 32'hA5, "host raw");
		rchk(OFS_STATUS, 32'hA5, "host status");
		`CHK(irq, 1'b1, "host irq")
		hostw(8'h5A);
		rchk(OFS_RAW, 32'hFF, "host raw all");
		axw(OFS_ENABLE, 32'h0F);
		rchk(OFS_STATUS, 32'h0F, "host partial");
		axw(OFS_CLEAR, 32'hFF);
		rchk(OFS_RAW, 32'h0, "host cleared");
		`CHK(irq, 1'b0, "irq idle")
	endtask : t_host

	task automatic t_rerun();
		axw(OFS_CONFIG, 32'h0000_000F);
		axw(OFS_ENABLE, 32'h0003_FFFF);
		hostw(8'h81);
		tick(2);
		`CHK(irq, 1'b1, "irq before reset")
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		tick(2);
		t_reset();
	endtask : t_rerun

	////////////////////////////////////////
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		conclude();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		tick(2);
		t_reset();
		t_map();
		t_config();
		t_events();
		t_host();
		t_rerun();
		conclude();
	end
endmodule : tb
